// File: bench/dao_rx_model.sv
`timescale 1ns/1ps
module dao_rx_model (
  input wire logic hclk,
  input wire logic [9:0] src_first,
  input wire logic [9:0] src_second,
  output logic [9:0] conv_first_code,
  output logic [9:0] conv_second_code,
  input wire logic [9:0] first_output_bus,
  input wire logic [9:0] second_output_bus,
  input wire logic channel_phase_flag,
  output logic [9:0] hi_word,
  output logic [9:0] lo_word,
  output logic [9:0] sec_word,
  output logic flag_hi,
  output logic flag_lo
);
  // codes move only in the clock-high half, so each falling-edge sample sees a settled word
  assign conv_first_code = src_first;
  assign conv_second_code = src_second;
  // capture in the clock-high half: first-channel word, second bus and flag
  always @(posedge hclk) begin
    #1;
    hi_word = first_output_bus;
    sec_word = second_output_bus;
    flag_hi = channel_phase_flag;
  end
  // capture in the clock-low half: second-channel word when multiplexed
  always @(negedge hclk) begin
    #1;
    lo_word = first_output_bus;
    flag_lo = channel_phase_flag;
  end
endmodule

// File: bench/dual_adc_output_and_control_test.sv
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fails++; \
  $display("BAD %0t got %h want %h", $time, a, b); end end
module dual_adc_output_and_control_test;
  import dao_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [9:0] src1 = 10'h155;
  logic [9:0] src2 = 10'h2AA;
  logic [9:0] c1, c2, b1, b2, hi, lo, sec;
  logic flag, fhi, flo;
  int fails = 0;
  int compares = 0;
  // free-running bus clock, 5 ns period
  always #2.5 hclk = ~hclk;
  dao_core #(.STANDBY_REQUEST_CYC(10), .PD_CYC(20)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(), .hrdata(hrdata),
    .conv_first_code(c1), .conv_second_code(c2), .first_output_bus(b1),
    .second_output_bus(b2), .channel_phase_flag(flag));
  dao_rx_model i_rx (.hclk(hclk), .src_first(src1), .src_second(src2), .conv_first_code(c1),
    .conv_second_code(c2), .first_output_bus(b1), .second_output_bus(b2),
    .channel_phase_flag(flag), .hi_word(hi), .lo_word(lo), .sec_word(sec), .flag_hi(fhi),
    .flag_lo(flo));
  task automatic stop_test();
    if (fails == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // one single-word transfer; the wait for hready is bounded so a stuck slave ends the run
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= a;
    htrans <= DAO_NONSEQ;
    hwrite <= w;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 20);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 20);
    rd = hrdata;
    if (n >= 20) begin fails++; stop_test(); end
  endtask
  // let the pipeline fill, then look after the model has captured
  task automatic gap(input int n);
    repeat (n) @(posedge hclk);
    #2;
  endtask
  task automatic t_par();
    gap(6);
    `CHK({hi, sec, fhi, flo}, {10'h155, 10'h2AA, 1'b1, 1'b0})
    @(posedge hclk);
    src1 <= 10'h3C3;
    src2 <= 10'h03C;
    gap(2);
    `CHK(hi, 10'h155)
    gap(1);
    `CHK({hi, sec}, {10'h3C3, 10'h03C})
  endtask
  task automatic t_fmt();
    ahb(1'b1, DAO_CTRL_OFS, 32'h03);
    gap(6); // first words after a format change are discarded
    `CHK({hi, sec}, {10'h1C3, 10'h23C})
  endtask
  task automatic t_mux();
    ahb(1'b1, DAO_CTRL_OFS, 32'h00);
    gap(6);
    `CHK({hi, lo, sec}, {10'h3C3, 10'h03C, 10'h000})
    `CHK({fhi, flo}, 2'b10)
  endtask
  task automatic t_pwr();
    ahb(1'b1, DAO_CTRL_OFS, 32'h05);
    gap(4);
    `CHK({hi, sec, fhi}, 21'h0)
    ahb(1'b0, DAO_STAT_OFS, 32'h0);
    `CHK(rd[2], 1'b1)
    ahb(1'b1, DAO_CTRL_OFS, 32'h01);
    ahb(1'b0, DAO_STAT_OFS, 32'h0);
    `CHK(rd[0], 1'b0)
    gap(16);
    `CHK(hi, src1)
    ahb(1'b1, DAO_CTRL_OFS, 32'h0D);
    gap(1); // power state follows the control write one edge later
    ahb(1'b0, DAO_STAT_OFS, 32'h0);
    `CHK({rd[3], rd[0], b2}, 12'h800)
    ahb(1'b1, DAO_CTRL_OFS, 32'h01);
    gap(12);
    `CHK(hi, 10'h000)
    gap(15);
    `CHK(hi, src1)
  endtask
  task automatic t_corr();
    int n;
    src1 <= 10'h203; // inputs held at zero differential
    src2 <= 10'h1FE;
    ahb(1'b1, DAO_CTRL_OFS, 32'h11);
    gap(1); // busy rises one edge after the start bit lands
    n = 0;
    do begin ahb(1'b0, DAO_STAT_OFS, 32'h0); n++; end while (rd[1] !== 1'b0 && n < 40);
    `CHK(n < 40, 1'b1)
    ahb(1'b0, DAO_OFFS_OFS, 32'h0);
    `CHK(rd, 32'h03FE0003)
    src1 <= 10'h250;
    src2 <= 10'h250;
    gap(6);
    `CHK({hi, sec}, {10'h24D, 10'h252})
  endtask
  // main sequence: reset, register defaults, then each mode in turn
  initial begin
    gap(4);
    `CHK({b1, b2, flag}, 21'h0)
    hresetn <= 1'b1;
    ahb(1'b0, DAO_CTRL_OFS, 32'h0);
    `CHK(rd, 32'h01)
    ahb(1'b0, DAO_OFFS_OFS, 32'h0);
    `CHK(rd, 32'h0)
    ahb(1'b0, 32'hC, 32'h0);
    `CHK(rd, 32'h0)
    t_par();
    t_fmt();
    t_mux();
    t_pwr();
    t_corr();
    stop_test();
  end
  // watchdog for the whole run
  initial begin
    #100000;
    fails++;
    stop_test();
  end
endmodule

// File: core/dao_core.sv
// Design decisions made here: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
// Operation
// - both channels sampled on clock falling edge
// - parallel mode: both buses driven together
// - mux mode: interleave on first, second low
// - correction start rising edge, 34 cycles
// - average 32 conversions, subtract afterwards
// - format bit: offset binary or twos complement
// - format change may corrupt one or two
// - both low runs; standby alone enters standby
// - standby exit valid after 800 ns
// - power-down; recovery under 1 ms
// - power-down wins over standby
// - line zero lsb, line nine msb
// - parallel data valid after rising edge
// - phase flag high: first channel on bus
// - phase flag edges follow channel switches
// - parallel: flag rises on each new pair
// - parallel latency 2.5 cycles
// - mux latency 2.5 first, 3 second
module dao_core
  import dao_pkg::*;
#(
  parameter int STANDBY_REQUEST_CYC = DAO_STANDBY_REQUEST_CYC,
  parameter int PD_CYC = DAO_PD_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [9:0] conv_first_code,
  input wire logic [9:0] conv_second_code,
  output logic [9:0] first_output_bus,
  output logic [9:0] second_output_bus,
  output logic channel_phase_flag
);
  // whole posedge state of the block
  typedef struct packed {
    logic [4:0] ctrl;          // bus, format, standby, power-down, correction start
    logic oc_prev;             // last correction start level, for edge detect
    dao_pwr_t pwr;             // power state
    logic [DAO_CW-1:0] rec;    // recovery countdown
    logic busy;                // correction running
    logic [5:0] ccnt;          // correction cycle index
    logic signed [15:0] acc1;  // correction sums
    logic signed [15:0] acc2;
    logic signed [9:0] off1;   // stored offsets
    logic signed [9:0] off2;
    logic [9:0] st1a;          // first pipeline stage
    logic [9:0] st1b;
    logic [9:0] st2a;          // corrected and formatted stage
    logic [9:0] st2b;
    logic [9:0] out1;          // first bus, clock high half
    logic [9:0] out2;          // second bus
    logic en;                  // outputs live
    logic wpend;               // write data phase pending
    logic [3:0] waddr;
    logic [31:0] rdata;
  } dao_st_t;

  dao_st_t st_ff, nxt_st;
  logic [9:0] smp1_ff, smp2_ff; // falling edge sample
  logic [9:0] lo_ff;            // first bus word for the clock low half
  logic [31:0] stat_w, offs_w;
  logic signed [9:0] sa, sb, ca, cb;
  logic take;

  // centre offset binary code on zero
  function automatic logic signed [9:0] dao_sgn(input logic [9:0] c);
    dao_sgn = $signed(c ^ DAO_MID);
  endfunction

  // subtract offset with saturation, so a large offset cannot wrap the code
  function automatic logic signed [9:0] dao_sub(input logic signed [9:0] v,
                                                input logic signed [9:0] o);
    logic signed [10:0] d;
    d = 11'(v) - 11'(o);
    if (d > 11'(DAO_SMAX)) begin
      dao_sub = DAO_SMAX;
    end else if (d < 11'(DAO_SMIN)) begin
      dao_sub = DAO_SMIN;
    end else begin
      dao_sub = d[9:0];
    end
  endfunction

  // analog result captured on the falling edge
  always_ff @(negedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      smp1_ff <= 10'h000;
      smp2_ff <= 10'h000;
      lo_ff <= 10'h000;
    end else begin
      smp1_ff <= conv_first_code;
      smp2_ff <= conv_second_code;
      // mux mode shows the second word half a cycle after the first
      lo_ff <= st_ff.ctrl[DAO_C_BUS] ? st_ff.out1 : st_ff.out2;
    end
  end

  assign stat_w = {28'h0000000, st_ff.pwr == DAO_PWD, st_ff.pwr == DAO_SBY, st_ff.busy,
                   st_ff.en};
  assign offs_w = {6'h00, st_ff.off2, 6'h00, st_ff.off1};
  assign take = hsel & hready & (htrans == DAO_NONSEQ);

  // next state
  always_comb begin
    nxt_st = st_ff;
    sa = dao_sgn(st_ff.st1a);
    sb = dao_sgn(st_ff.st1b);
    ca = dao_sub(sa, st_ff.off1);
    cb = dao_sub(sb, st_ff.off2);
    // bus write lands in the data phase
    if (st_ff.wpend && st_ff.waddr == DAO_CTRL_OFS) begin
      nxt_st.ctrl = hwdata[4:0];
    end
    nxt_st.wpend = take & hwrite;
    nxt_st.waddr = haddr[3:0];
    // read data is set up during the address phase so reads need no wait
    if (take && !hwrite) begin
      case (haddr[3:0])
        DAO_CTRL_OFS: nxt_st.rdata = {27'h0, st_ff.ctrl};
        DAO_STAT_OFS: nxt_st.rdata = stat_w;
        DAO_OFFS_OFS: nxt_st.rdata = offs_w;
        default: nxt_st.rdata = 32'h00000000; // unmapped reads zero
      endcase
    end
    // power state, power-down checked first
    if (st_ff.ctrl[DAO_C_PD]) begin
      nxt_st.pwr = DAO_PWD;
      nxt_st.rec = DAO_CW'(PD_CYC);
      nxt_st.en = 1'b0;
    end else if (st_ff.ctrl[DAO_C_STANDBY_REQUEST]) begin
      nxt_st.pwr = DAO_SBY;
      if (st_ff.pwr != DAO_PWD) begin
        nxt_st.rec = DAO_CW'(STANDBY_REQUEST_CYC);
      end
      nxt_st.en = 1'b0;
    end else begin
      nxt_st.pwr = DAO_RUN;
      // outputs stay quiet until the wake-up time runs out
      if (st_ff.rec != '0) begin
        nxt_st.rec = st_ff.rec - 1'b1;
      end
      nxt_st.en = (st_ff.rec == '0);
    end
    // conversion pipeline
    nxt_st.st1a = smp1_ff;
    nxt_st.st1b = smp2_ff;
    // format bit is read each cycle, so a change spoils at most two words
    if (st_ff.ctrl[DAO_C_FMT]) begin
      nxt_st.st2a = ca;
      nxt_st.st2b = cb;
    end else begin
      nxt_st.st2a = ca ^ DAO_MID;
      nxt_st.st2b = cb ^ DAO_MID;
    end
    if (st_ff.en) begin
      nxt_st.out1 = st_ff.st2a;
      nxt_st.out2 = st_ff.st2b;
    end else begin
      nxt_st.out1 = 10'h000;
      nxt_st.out2 = 10'h000;
    end
    // correction sequence
    nxt_st.oc_prev = st_ff.ctrl[DAO_C_OC];
    if (st_ff.ctrl[DAO_C_OC] && !st_ff.oc_prev && !st_ff.busy &&
        st_ff.pwr == DAO_RUN) begin
      nxt_st.busy = 1'b1;
      nxt_st.ccnt = 6'h00;
      nxt_st.acc1 = 16'sh0000;
      nxt_st.acc2 = 16'sh0000;
    end else if (st_ff.busy) begin
      nxt_st.ccnt = st_ff.ccnt + 6'h01;
      // first cycles flush the pipeline; the rest are summed raw
      if (st_ff.ccnt >= DAO_CORR_SKIP) begin
        nxt_st.acc1 = st_ff.acc1 + 16'(sa);
        nxt_st.acc2 = st_ff.acc2 + 16'(sb);
      end
      if (st_ff.ccnt == DAO_CORR_LAST) begin
        nxt_st.busy = 1'b0;
        nxt_st.off1 = 10'((st_ff.acc1 + 16'(sa)) >>> DAO_AVG_SHIFT);
        nxt_st.off2 = 10'((st_ff.acc2 + 16'(sb)) >>> DAO_AVG_SHIFT);
      end
    end
  end

  // single state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= '{ctrl: DAO_CTRL_RST, pwr: DAO_RUN, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // output drive
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st_ff.rdata;
  // second bus forced low in mux mode
  assign second_output_bus = st_ff.ctrl[DAO_C_BUS] ? st_ff.out2 : 10'h000;
  // clock high half shows the first word, low half the held word
  assign first_output_bus = hclk ? st_ff.out1 : lo_ff;
  // flag follows the clock: rises with each new word pair or first-channel word
  assign channel_phase_flag = hclk & st_ff.en;

  // checks
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  pd_priority_a: assert property (st_ff.ctrl[DAO_C_PD] |=> st_ff.pwr == DAO_PWD)
    else $error("power-down did not win");
  standby_request_entry_a: assert property (
    st_ff.ctrl[DAO_C_STANDBY_REQUEST] && !st_ff.ctrl[DAO_C_PD] |=> st_ff.pwr == DAO_SBY)
    else $error("standby not entered");
  quiet_off_a: assert property (st_ff.pwr != DAO_RUN |-> !st_ff.en ##1 st_ff.out1 == 10'h000)
    else $error("output live in low power");
  mux_low_a: assert property (!st_ff.ctrl[DAO_C_BUS] |-> second_output_bus == 10'h000)
    else $error("second bus not low");
  // busy covers index 0 through 33, so it drops on the 34th sample after its rise
  corr_len_a: assert property ($rose(st_ff.busy) |-> st_ff.busy [*8] ##27 !st_ff.busy)
    else $error("correction length wrong");
  par_lat_a: assert property (st_ff.en && $past(st_ff.en) && st_ff.ctrl[DAO_C_FMT]
    |=> st_ff.out1 == $past(st_ff.st2a))
    else $error("parallel latency wrong");
  fmt_ob_a: assert property (!st_ff.ctrl[DAO_C_FMT] |=>
    st_ff.st2a == (10'($past(ca)) ^ DAO_MID))
    else $error("offset binary wrong");
  off_hold_a: assert property (!st_ff.busy && !$rose(st_ff.busy) |=> $stable(st_ff.off1))
    else $error("offset changed outside sequence");
  // the flag is gated by the clock, so it is high through the whole clock-high half and is checked just before the falling edge
  flag_hi_a: assert property (@(negedge hclk) st_ff.en |-> channel_phase_flag)
    else $error("flag low in high half");

  // a clean rising edge on the start bit launches a fresh sequence at index zero
  oc_start_a: assert property (st_ff.ctrl[DAO_C_OC] && !st_ff.oc_prev && !st_ff.busy &&
    st_ff.pwr == DAO_RUN |=> st_ff.busy && st_ff.ccnt == 6'h00)
    else $error("correction did not start");
  // the index never runs past its last step while busy
  corr_cnt_a: assert property (st_ff.busy |-> st_ff.ccnt <= DAO_CORR_LAST)
    else $error("correction index overran");
  // low half of the first bus carries the second word one half cycle later
  mux_half_a: assert property (@(negedge hclk) !st_ff.ctrl[DAO_C_BUS] |=>
    lo_ff == $past(st_ff.out2))
    else $error("second word missing in low half");
  // parallel mode shows the second channel on its own bus
  par_both_a: assert property (st_ff.ctrl[DAO_C_BUS] |-> second_output_bus == st_ff.out2)
    else $error("second bus not driven");
  // a disabled output stage blanks both words on the next edge
  blank_out_a: assert property (!st_ff.en |=> st_ff.out1 == 10'h000 &&
    st_ff.out2 == 10'h000)
    else $error("outputs not blanked");
  // once the wake-up count is spent and no low-power request stands, outputs go live
  wake_live_a: assert property (st_ff.pwr == DAO_RUN && st_ff.rec == '0 &&
    !st_ff.ctrl[DAO_C_STANDBY_REQUEST] && !st_ff.ctrl[DAO_C_PD] |=> st_ff.en)
    else $error("outputs not live after recovery");
  // power-down always reloads the long recovery count
  pd_reload_a: assert property (st_ff.ctrl[DAO_C_PD] |=> st_ff.rec == DAO_CW'(PD_CYC))
    else $error("recovery count not reloaded");
  // twos complement mode passes the corrected signed value straight through
  fmt_tc_a: assert property (st_ff.ctrl[DAO_C_FMT] |=> st_ff.st2a == 10'($past(ca)))
    else $error("twos complement wrong");

  corr_run_c: cover property ($fell(st_ff.busy));
  standby_request_wake_c: cover property ($fell(st_ff.ctrl[DAO_C_STANDBY_REQUEST]) ##[1:200] st_ff.en);
  mux_run_c: cover property (!st_ff.ctrl[DAO_C_BUS] && st_ff.en && st_ff.out2 != 10'h000);
  // recovery from power-down back to live output
  pd_wake_c: cover property ($fell(st_ff.ctrl[DAO_C_PD]) ##[1:40] st_ff.en);
endmodule

// File: shared/dao_pkg.sv
package dao_pkg;
  // register byte offsets
  localparam logic [3:0] DAO_CTRL_OFS = 4'h0;
  localparam logic [3:0] DAO_STAT_OFS = 4'h4;
  localparam logic [3:0] DAO_OFFS_OFS = 4'h8;
  // control register fields
  localparam int DAO_C_BUS = 0;
  localparam int DAO_C_FMT = 1;
  localparam int DAO_C_STANDBY_REQUEST = 2;
  localparam int DAO_C_PD = 3;
  localparam int DAO_C_OC = 4;
  localparam logic [4:0] DAO_CTRL_RST = 5'h01;
  // offset register field position of the second channel
  localparam int DAO_OFS_HI = 16;
  // converter word layout
  localparam int DAO_W = 10;
  localparam logic [9:0] DAO_MID = 10'h200;
  localparam logic signed [9:0] DAO_SMAX = 10'sh1FF;
  localparam logic signed [9:0] DAO_SMIN = -10'sh200;
  // correction sequence
  localparam logic [5:0] DAO_CORR_LAST = 6'h21;
  localparam logic [5:0] DAO_CORR_SKIP = 6'h02;
  localparam int DAO_AVG_SHIFT = 5;
  // timing
  localparam int DAO_CLK_PS = 5000;
  localparam int DAO_STANDBY_REQUEST_NS = 800;
  localparam int DAO_STANDBY_REQUEST_CYC = (DAO_STANDBY_REQUEST_NS * 1000) / DAO_CLK_PS;
  localparam int DAO_PD_MS = 1;
  localparam int DAO_PD_CYC = (DAO_PD_MS * 1000000000) / DAO_CLK_PS;
  localparam int DAO_CW = 18;
  // AHB transfer type
  localparam logic [1:0] DAO_NONSEQ = 2'h2;
  // power state, one-hot
  typedef enum logic [2:0] {
    DAO_RUN = 3'h1,
    DAO_SBY = 3'h2,
    DAO_PWD = 3'h4
  } dao_pwr_t;
endpackage
